// >>> testbench/pirq_bank_monitor.sv
// Port-level checker for the interrupt flag/enable bank
`timescale 1ns/1ps
module pirq_bank_monitor
    import pirq_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       reset,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr_stb,
    input wire logic       rd_stb,
    input wire logic [7:0] rdata,
    input wire logic       timer0_overflow,
    input wire logic       ext_pin_event,
    input wire logic [4:0] pin_change_port_flags,
    input wire logic       osc_failsafe_event,
    input wire logic       clock_switch_ready,
    input wire logic       conversion_done,
    input wire logic       periph_req_q,
    input wire logic       irq_q
);
    logic [7:0] f1_ev;
    assign f1_ev = {osc_failsafe_event, clock_switch_ready, 5'h00, conversion_done};
    default clocking mon_cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    // ****************************************
    // Flag, layout and gating properties
    // ****************************************
    a_tmr0_flag_set: assert property (
        timer0_overflow ##1 (rd_stb && addr == PIRQ_ADDR_FLAGS0) |=> rdata[5])
        else $error("timer0 flag not seen");
    a_ext_flag_set: assert property (
        ext_pin_event ##1 (rd_stb && addr == PIRQ_ADDR_FLAGS0) |=> rdata[0])
        else $error("pin flag not seen");
    a_f1_flags_set: assert property (
        (f1_ev != 8'h00) ##1 (rd_stb && addr == PIRQ_ADDR_FLAGS1)
        |=> (rdata & $past(f1_ev, 2)) == $past(f1_ev, 2))
        else $error("flags1 event lost");
    a_pinchg_live: assert property (
        rd_stb && addr == PIRQ_ADDR_FLAGS0 |=> rdata[4] == $past(|pin_change_port_flags))
        else $error("summary flag wrong");
    a_en6_unused_zero: assert property (
        rd_stb && addr == PIRQ_ADDR_EN6 |=> rdata[7:2] == 6'h00)
        else $error("enable6 spare bits set");
    a_en7_unused_zero: assert property (
        rd_stb && addr == PIRQ_ADDR_EN7 |=> rdata[7:6] == 2'h0 && rdata[3:1] == 3'h0)
        else $error("enable7 spare bits set");
    a_reset_clears: assert property (
        $fell(reset) |-> !irq_q && !periph_req_q && rdata == 8'h00)
        else $error("outputs not clear after reset");
    a_global_blocks: assert property (
        wr_stb && addr == PIRQ_ADDR_GATE && !wdata[PIRQ_BIT_GLOBAL] |-> ##2 !irq_q)
        else $error("request passed global gate");
endmodule

bind pirq_bank pirq_bank_monitor mon (.*);

// >>> testbench/pirq_bank_tb.sv
// Self-checking bench of the interrupt flag/enable bank
`timescale 1ns/1ps
module pirq_bank_tb
    import pirq_pkg::*;
;
    logic       ref_clk;
    logic       reset;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr_stb;
    logic       rd_stb;
    logic [7:0] rdata;
    logic [4:0] ev_req;
    logic [4:0] ev_out;
    logic       slow;
    wire logic  timer0_overflow    = ev_out[4];
    wire logic  ext_pin_event      = ev_out[3];
    wire logic  osc_failsafe_event = ev_out[2];
    wire logic  clock_switch_ready = ev_out[1];
    wire logic  conversion_done    = ev_out[0];
    logic [4:0] pin_change_port_flags;
    logic [7:0] en5_src_flags;
    logic [7:0] en6_src_flags;
    logic [7:0] en7_src_flags;
    logic       periph_req_q;
    logic       irq_q;
    logic [1:0] op;
    logic       started;
    int         fails;
    int         cmp_count;
    int         seed;
    int         r;
    int         r2;
    int         m_reg[8];
    int         mask[8];
    int         m_rd;
    int         m_irq;
    int         m_prq;
    int         f0v;
    int         grpp;

    pirq_bank uut (.*);
    pirq_src_model src (.ref_clk, .reset, .slow, .ev_req, .ev_out);

    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // ****************************************
    // Reference model and comparisons
    // ****************************************
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            m_reg = '{default: 0};
            m_rd = 0;
            m_irq = 0;
            m_prq = 0;
        end
        else
        begin
            f0v = m_reg[3] | ((|pin_change_port_flags) ? 16 : 0);
            m_rd = (rd_stb && !addr[3]) ? ((addr == 4'h3) ? f0v : m_reg[addr[2:0]]) : 0;
            grpp = (m_reg[4] & m_reg[7]) | (en5_src_flags & m_reg[0])
                 | (en6_src_flags & m_reg[1]) | (en7_src_flags & m_reg[2]);
            m_prq = grpp != 0;
            m_irq = m_reg[5][7] && ((f0v & m_reg[6]) != 0 || (m_reg[5][6] && m_prq));
            if (wr_stb && !addr[3])
                m_reg[addr[2:0]] = wdata & mask[addr[2:0]];
            m_reg[3] |= {timer0_overflow, 4'h0, ext_pin_event};
            m_reg[4] |= {osc_failsafe_event, clock_switch_ready, 5'h00, conversion_done};
        end
    end

    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic chk1(input string n, input logic e, input logic g);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("BAD %s exp %b got %b", n, e, g);
        end
    endtask

    always @(negedge ref_clk)
    begin
        if (started)
        begin
            chk8("rdata", m_rd[7:0], rdata);
            chk1("irq_q", m_irq[0], irq_q);
            chk1("periph_req_q", m_prq[0], periph_req_q);
        end
    end

    task automatic bus(input logic w, input logic rd, input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr_stb <= w;
        rd_stb <= rd;
        addr <= a;
        wdata <= d;
    endtask

    task automatic end_test(input string n);
        $display("test %s done, %0d mismatches", n, fails);
    endtask

    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        {reset, started, slow} = 3'b100;
        {wr_stb, rd_stb, addr, wdata, ev_req} = '0;
        {pin_change_port_flags, en5_src_flags, en6_src_flags, en7_src_flags} = '0;
        fails = 0;
        cmp_count = 0;
        seed = 34463;
        mask = '{PIRQ_EN5_MASK, PIRQ_EN6_MASK, PIRQ_EN7_MASK, PIRQ_F0_SW_MASK,
                 PIRQ_F1_MASK, PIRQ_GATE_MASK, PIRQ_EN0_MASK, PIRQ_EN1_MASK};
        @(posedge ref_clk);
        started = 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        for (int a = 0; a < 16; a++)
            bus(1'b0, 1'b1, a[3:0], 8'h00);
        end_test("reset");
        bus(1'b1, 1'b0, PIRQ_ADDR_FLAGS0, 8'h00);
        bus(1'b1, 1'b0, PIRQ_ADDR_EN0, 8'h31);
        bus(1'b1, 1'b0, PIRQ_ADDR_GATE, 8'h80);
        ev_req <= 5'h18;
        bus(1'b1, 1'b0, PIRQ_ADDR_FLAGS0, 8'h00);
        ev_req <= 5'h00;
        repeat (2) bus(1'b0, 1'b1, PIRQ_ADDR_FLAGS0, 8'h00);
        bus(1'b1, 1'b0, PIRQ_ADDR_FLAGS0, 8'h00);
        bus(1'b0, 1'b1, PIRQ_ADDR_FLAGS0, 8'h00);
        bus(1'b0, 1'b0, 4'h0, 8'h00);
        end_test("directed");
        // Strobes idle around the mid-run reset so none lands inside it
        for (int i = 0; i < 3000; i++)
        begin
            r = $random(seed);
            r2 = $random(seed);
            slow <= i[9];
            reset <= (i >= 1500 && i < 1503);
            ev_req <= r[4:0] & r[9:5] & r[14:10];
            if (r[17:15] == 3'h0)
                pin_change_port_flags <= r[22:18];
            en5_src_flags <= r[30:23];
            en6_src_flags <= r2[31:24];
            en7_src_flags <= r2[23:16];
            op = (i >= 1499 && i < 1503) ? 2'h0 : r2[13:12];
            bus(op == 2'h1, op == 2'h2, r2[3:0], r2[11:4]);
        end
        end_test("random");
        conclude;
    end

    initial
    begin
        #100us;
        fails++;
        conclude;
    end
endmodule

// >>> testbench/pirq_src_model.sv
// Partner model: peripheral event sources, prompt or one cycle slower
`timescale 1ns/1ps
module pirq_src_model
(
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       slow,
    input  wire logic [4:0] ev_req,
    output logic      [4:0] ev_out
);
    logic [4:0] d1_q;
    logic [4:0] d2_q;
    // Slow path mimics a source behind an extra resync stage
    always_ff @(posedge ref_clk)
    begin
        d1_q <= reset ? 5'h00 : ev_req;
        d2_q <= reset ? 5'h00 : d1_q;
    end
    assign ev_out = slow ? d2_q : d1_q;
endmodule

// >>> verilog/pirq_bank.sv
// Top: peripheral interrupt enable/flag bank with request gating
//
// Operation
// - Flags set on their source event regardless of any enable bit.
// - Enable 5 holds logic cell 4..1 enables in bits 7..4 and timer1 gate in bit 0.
// - Enable 6 holds capture/compare 2 and 1 enables in bits 1 and 0.
// - Enable 7 holds nonvolatile task in bit 5, osc rollover in bit 4, waveform gen in bit 0.
// - Flag 0 bit 5 is set by timer0 overflow and held until software writes zero.
// - Flag 0 bit 4 is read-only and equals the OR of all pin-change port flags.
// - Flag 0 bit 0 is set by the external pin event and cleared by software.
// - Flag 1 bit 7 is set by an oscillator fail-safe event and held until cleared.
// - Flag 1 bit 6 is set when clock switch logic is ready and cleared by software.
// - Flag 1 bit 0 is set when a conversion completes and held until cleared.
// - All stored bits reset to zero at every reset; flag 0 bit 4 is a live OR and is not reset.
// - Peripheral-gated sources need both peripheral and global enable; group 0 needs only global.
// - Global enable low blocks every request at irq_q; periph_req_q is not gated by it.
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
module pirq_bank
    import pirq_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_stb,
    input  wire logic       rd_stb,
    output logic      [7:0] rdata,
    input  wire logic       timer0_overflow,
    input  wire logic       ext_pin_event,
    input  wire logic [4:0] pin_change_port_flags,
    input  wire logic       osc_failsafe_event,
    input  wire logic       clock_switch_ready,
    input  wire logic       conversion_done,
    input  wire logic [7:0] en5_src_flags,
    input  wire logic [7:0] en6_src_flags,
    input  wire logic [7:0] en7_src_flags,
    output logic            periph_req_q,
    output logic            irq_q
);
    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [7:0] en5_q;
    logic [7:0] en6_q;
    logic [7:0] en7_q;
    logic [7:0] en0_q;
    logic [7:0] en1_q;
    logic [7:0] gate_q;
    logic [7:0] flags0_q;
    logic [7:0] flags1_q;
    logic [7:0] set0;
    logic [7:0] set1;
    logic       pin_change_summary_flag;
    logic [7:0] flags0_view;
    logic       global_irq_en;
    logic       peripheral_irq_gate_en;
    logic       grp0_req;
    logic       grp_periph_req;

    // Enable 5 layout
    pirq_en_reg #(.MASK(PIRQ_EN5_MASK)) u_en5
    (
        .ref_clk (ref_clk),
        .reset   (reset),
        .wr_i    (wr_stb && (addr == PIRQ_ADDR_EN5)),
        .wdata_i (wdata),
        .en_q    (en5_q)
    );

    // Enable 6 layout
    pirq_en_reg #(.MASK(PIRQ_EN6_MASK)) u_en6
    (
        .ref_clk (ref_clk),
        .reset   (reset),
        .wr_i    (wr_stb && (addr == PIRQ_ADDR_EN6)),
        .wdata_i (wdata),
        .en_q    (en6_q)
    );

    // Enable 7 layout
    pirq_en_reg #(.MASK(PIRQ_EN7_MASK)) u_en7
    (
        .ref_clk (ref_clk),
        .reset   (reset),
        .wr_i    (wr_stb && (addr == PIRQ_ADDR_EN7)),
        .wdata_i (wdata),
        .en_q    (en7_q)
    );

    // Enables for flag groups 0 and 1, kept locally so gating is complete
    pirq_en_reg #(.MASK(PIRQ_EN0_MASK)) u_en0
    (
        .ref_clk (ref_clk),
        .reset   (reset),
        .wr_i    (wr_stb && (addr == PIRQ_ADDR_EN0)),
        .wdata_i (wdata),
        .en_q    (en0_q)
    );

    pirq_en_reg #(.MASK(PIRQ_EN1_MASK)) u_en1
    (
        .ref_clk (ref_clk),
        .reset   (reset),
        .wr_i    (wr_stb && (addr == PIRQ_ADDR_EN1)),
        .wdata_i (wdata),
        .en_q    (en1_q)
    );

    pirq_en_reg #(.MASK(PIRQ_GATE_MASK)) u_gate
    (
        .ref_clk (ref_clk),
        .reset   (reset),
        .wr_i    (wr_stb && (addr == PIRQ_ADDR_GATE)),
        .wdata_i (wdata),
        .en_q    (gate_q)
    );

    // ****************************************************************
    // Hardware set events
    // ****************************************************************
    always_comb
    begin
        set0 = PIRQ_RESET_VAL;
        set1 = PIRQ_RESET_VAL;
        // Ungated set paths
        // Timer0 overflow set
        set0[PIRQ_BIT_TMR0] = timer0_overflow;
        // External pin set
        set0[PIRQ_BIT_EXTPIN] = ext_pin_event;
        // Fail-safe set
        set1[PIRQ_BIT_OSCF] = osc_failsafe_event;
        // Clock switch set
        set1[PIRQ_BIT_CSW] = clock_switch_ready;
        // Conversion done set
        set1[PIRQ_BIT_CONV] = conversion_done;
    end

    // Set wins over clear
    pirq_flag_reg #(.MASK(PIRQ_F0_SW_MASK)) u_flags0
    (
        .ref_clk (ref_clk),
        .reset   (reset),
        .set_i   (set0),
        .wr_i    (wr_stb && (addr == PIRQ_ADDR_FLAGS0)),
        .wdata_i (wdata),
        .flag_q  (flags0_q)
    );

    pirq_flag_reg #(.MASK(PIRQ_F1_MASK)) u_flags1
    (
        .ref_clk (ref_clk),
        .reset   (reset),
        .set_i   (set1),
        .wr_i    (wr_stb && (addr == PIRQ_ADDR_FLAGS1)),
        .wdata_i (wdata),
        .flag_q  (flags1_q)
    );

    // Live OR, no storage
    assign pin_change_summary_flag = |pin_change_port_flags;

    always_comb
    begin
        flags0_view = flags0_q;
        flags0_view[PIRQ_BIT_PINCHG] = pin_change_summary_flag;
    end

    // ****************************************************************
    // Request gating
    // ****************************************************************
    assign global_irq_en          = gate_q[PIRQ_BIT_GLOBAL];
    assign peripheral_irq_gate_en = gate_q[PIRQ_BIT_PERIPH];

    // Flag AND enable, ORed
    assign grp0_req       = |(flags0_view & en0_q);
    assign grp_periph_req = |(flags1_q & en1_q)
                          | |(en5_src_flags & en5_q)
                          | |(en6_src_flags & en6_q)
                          | |(en7_src_flags & en7_q);

    // All outputs cleared
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            periph_req_q <= 1'b0;
            irq_q        <= 1'b0;
        end
        else
        begin
            periph_req_q <= grp_periph_req;
            // Peripheral gate needed
            // Global enable blocks all
            irq_q <= global_irq_en
                   && (grp0_req || (peripheral_irq_gate_en && grp_periph_req));
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            rdata <= PIRQ_RESET_VAL;
        end
        else if (rd_stb)
        begin
            // Unmapped addresses read zero
            if (addr == PIRQ_ADDR_EN5)
            begin
                rdata <= en5_q;
            end
            else if (addr == PIRQ_ADDR_EN6)
            begin
                rdata <= en6_q;
            end
            else if (addr == PIRQ_ADDR_EN7)
            begin
                rdata <= en7_q;
            end
            else if (addr == PIRQ_ADDR_FLAGS0)
            begin
                rdata <= flags0_view;
            end
            else if (addr == PIRQ_ADDR_FLAGS1)
            begin
                rdata <= flags1_q;
            end
            else if (addr == PIRQ_ADDR_GATE)
            begin
                rdata <= gate_q;
            end
            else if (addr == PIRQ_ADDR_EN0)
            begin
                rdata <= en0_q;
            end
            else if (addr == PIRQ_ADDR_EN1)
            begin
                rdata <= en1_q;
            end
            else
            begin
                rdata <= PIRQ_RESET_VAL;
            end
        end
        else
        begin
            rdata <= PIRQ_RESET_VAL;
        end
    end
endmodule

// >>> verilog/pirq_en_reg.sv
// Plain masked read/write enable register
`timescale 1ns/1ps
module pirq_en_reg
    import pirq_pkg::*;
#(
    parameter logic [7:0] MASK = 8'h00
)
(
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       wr_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] en_q
);
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            en_q <= PIRQ_RESET_VAL;
        end
        else if (wr_i)
        begin
            en_q <= wdata_i & MASK;
        end
    end
endmodule

// >>> verilog/pirq_flag_reg.sv
// Sticky flag register: hardware set, software write-zero clear
`timescale 1ns/1ps
module pirq_flag_reg
    import pirq_pkg::*;
#(
    parameter logic [7:0] MASK = 8'h00
)
(
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic [7:0] set_i,
    input  wire logic       wr_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] flag_q
);
    logic [7:0] flag_d;

    always_comb
    begin
        flag_d = flag_q;
        if (wr_i)
        begin
            flag_d = wdata_i & MASK;
        end
        // Set beats a same-cycle clear
        flag_d = (flag_d | set_i) & MASK;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            flag_q <= PIRQ_RESET_VAL;
        end
        else
        begin
            flag_q <= flag_d;
        end
    end
endmodule

// >>> verilog/pirq_pkg.sv
// Package: register map, field positions and reset values of the interrupt flag/enable bank
package pirq_pkg;

    localparam logic [3:0] PIRQ_ADDR_EN5    = 4'h0;
    localparam logic [3:0] PIRQ_ADDR_EN6    = 4'h1;
    localparam logic [3:0] PIRQ_ADDR_EN7    = 4'h2;
    localparam logic [3:0] PIRQ_ADDR_FLAGS0 = 4'h3;
    localparam logic [3:0] PIRQ_ADDR_FLAGS1 = 4'h4;
    localparam logic [3:0] PIRQ_ADDR_GATE   = 4'h5;
    localparam logic [3:0] PIRQ_ADDR_EN0    = 4'h6;
    localparam logic [3:0] PIRQ_ADDR_EN1    = 4'h7;

    localparam logic [7:0] PIRQ_RESET_VAL   = 8'h00;

    localparam logic [7:0] PIRQ_EN5_MASK    = 8'hF1;
    localparam logic [7:0] PIRQ_EN6_MASK    = 8'h03;
    localparam logic [7:0] PIRQ_EN7_MASK    = 8'h31;
    localparam logic [7:0] PIRQ_F0_SW_MASK  = 8'h21;
    localparam logic [7:0] PIRQ_F1_MASK     = 8'hC1;
    localparam logic [7:0] PIRQ_EN0_MASK    = 8'h31;
    localparam logic [7:0] PIRQ_EN1_MASK    = 8'hC1;
    localparam logic [7:0] PIRQ_GATE_MASK   = 8'hC0;

    localparam int PIRQ_BIT_TMR0   = 5;
    localparam int PIRQ_BIT_PINCHG = 4;
    localparam int PIRQ_BIT_EXTPIN = 0;
    localparam int PIRQ_BIT_OSCF   = 7;
    localparam int PIRQ_BIT_CSW    = 6;
    localparam int PIRQ_BIT_CONV   = 0;
    localparam int PIRQ_BIT_GLOBAL = 7;
    localparam int PIRQ_BIT_PERIPH = 6;

    localparam int PIRQ_PORTS      = 5;

endpackage
